/* File: hdl/lcm_pkg.sv */
// Shared constants and types for the light curtain mode control
package lcm_pkg;

  // ************************************************
  // Clock and timing
  // ************************************************
  localparam int CLK_KHZ       = 250000;
  localparam int ALIGN_OPEN_MS = 1000;
  localparam int HOLD_MIN_MS   = 500;
  localparam int HOLD_MAX_MS   = 4000;
  // Exact multiples of the clock, so no rounding is needed
  localparam int ALIGN_OPEN_CYC = ALIGN_OPEN_MS * CLK_KHZ;
  localparam int HOLD_MIN_CYC   = HOLD_MIN_MS * CLK_KHZ;
  localparam int HOLD_MAX_CYC   = HOLD_MAX_MS * CLK_KHZ;
  localparam int CNT_W          = 30;
  localparam int SYNC_STAGES    = 2;

  // ************************************************
  // Indicator codes
  // ************************************************
  localparam logic [2:0] IND_DARK       = 3'h0;
  localparam logic [2:0] IND_NO_SYNC    = 3'h1;
  localparam logic [2:0] IND_BLOCKED    = 3'h2;
  localparam logic [2:0] IND_WEAK       = 3'h3;
  localparam logic [2:0] IND_MEDIUM     = 3'h4;
  localparam logic [2:0] IND_MAX        = 3'h5;
  localparam logic [2:0] IND_LOCK_OFF   = 3'h6;
  localparam logic [2:0] IND_LOCK_READY = 3'h7;

  // ************************************************
  // Received signal strength levels
  // ************************************************
  localparam logic [1:0] LVL_WEAK   = 2'h0;
  localparam logic [1:0] LVL_MEDIUM = 2'h1;
  localparam logic [1:0] LVL_MAX    = 2'h2;

  localparam logic [1:0] SSW_OFF = 2'h0;
  localparam logic [1:0] SSW_ON  = 2'h3;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [4:0] {
    ST_POWERUP = 5'h01,
    ST_ALIGN   = 5'h02,
    ST_RUN     = 5'h04,
    ST_TRIP    = 5'h08,
    ST_LOCK    = 5'h10
  } lcm_state_t;

  typedef struct packed {
    logic       rearm_closed;
    logic       select_bridged;
    logic       reset_btn;
    logic       sync_beam;
    logic       beams_clear;
    logic [1:0] level;
  } lcm_pins_t;

  typedef struct packed {
    logic align_mode;
    logic auto_rearm;
    logic manual_rearm;
    logic rearm_lock;
    logic sync_lost;
  } lcm_status_t;

  localparam int PINS_W = $bits(lcm_pins_t);

endpackage

/* File: hdl/lcm_sync.sv */
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ps
module lcm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;

  // ************************************************
  // Per-bit stages
  // ************************************************
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        meta_q[b] <= 1'b0;
        hold_q[b] <= 1'b0;
      end else begin
        meta_q[b] <= i_d[b];
        hold_q[b] <= meta_q[b];
      end
    end
  end

  assign o_q = hold_q;
endmodule

/* File: hdl/lcm_press.sv */
// Reset button hold timer with press-and-release window check
`timescale 1ns/1ps
module lcm_press
  import lcm_pkg::*;
#(
  parameter int P_MIN = HOLD_MIN_CYC,
  parameter int P_MAX = HOLD_MAX_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Button, synchronised, high while pressed
  input  wire logic i_btn,
  // One-cycle pulse on a release inside the window
  output logic      o_valid
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             held_q;
  logic             valid_q;
  wire              release_w = held_q && !i_btn;
  wire              sat_w     = cnt_q > CNT_W'(P_MAX);
  wire              in_win_w  = (cnt_q >= CNT_W'(P_MIN)) &&
                                (cnt_q <= CNT_W'(P_MAX));

  // Saturate just past the window so long holds stay rejected
  assign cnt_d = !i_btn ? '0 : (sat_w ? cnt_q : cnt_q + 1'b1);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q   <= '0;
      held_q  <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      held_q  <= i_btn;
      valid_q <= release_w && in_win_w;
    end
  end

  assign o_valid = valid_q;

  property p_short_press;
    @(posedge i_clk) disable iff (!i_nrst)
    (release_w && cnt_q < CNT_W'(P_MIN)) |=> !o_valid;
  endproperty
  a_short_press: assert property (p_short_press)
    else $error("Short press accepted");

  property p_long_press;
    @(posedge i_clk) disable iff (!i_nrst)
    (release_w && sat_w) |=> !o_valid;
  endproperty
  a_long_press: assert property (p_long_press)
    else $error("Over-long press accepted");
endmodule

/* File: hdl/lcm_top.sv */
// Mode, indicator and safety output control of the curtain receiver
`timescale 1ns/1ps
module lcm_top #(
  parameter int P_ALIGN_CYC = lcm_pkg::ALIGN_OPEN_CYC,
  parameter int P_HOLD_MIN  = lcm_pkg::HOLD_MIN_CYC,
  parameter int P_HOLD_MAX  = lcm_pkg::HOLD_MAX_CYC
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  // Wiring, optics and button pins
  input  wire lcm_pkg::lcm_pins_t  i_pins,
  // Machine side
  output logic               [1:0] o_safety_switch_outputs,
  // Indicator and status
  output logic               [2:0] o_indicator,
  output lcm_pkg::lcm_status_t     o_status
);
  import lcm_pkg::*;

  // ************************************************
  // Declarations
  // ************************************************
  lcm_pins_t        pins_s;
  lcm_state_t       state_q;
  lcm_state_t       state_d;
  logic [CNT_W-1:0] open_cnt_q;
  logic [CNT_W-1:0] open_cnt_d;
  logic             align_only_q;
  logic             auto_q;
  logic             manual_q;
  logic [1:0]       ssw_q;
  logic [1:0]       ssw_d;
  logic [2:0]       ind_q;
  logic [2:0]       ind_d;
  lcm_status_t      status_q;
  lcm_status_t      status_d;
  logic             press_ok;

  // ************************************************
  // Input synchronisation
  // ************************************************
  lcm_sync #(
    .W (PINS_W)
  ) u_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (i_pins),
    .o_q    (pins_s)
  );

  // ************************************************
  // Reset button timer
  // ************************************************
  lcm_press #(
    .P_MIN (P_HOLD_MIN),
    .P_MAX (P_HOLD_MAX)
  ) u_press (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_btn   (pins_s.reset_btn),
    .o_valid (press_ok)
  );

  // ************************************************
  // Wiring and optics decode
  // ************************************************
  // Bridge wins over a closed contact: a bridge also closes it
  wire sel_auto   = pins_s.select_bridged;
  wire sel_manual = !pins_s.select_bridged &&
                    pins_s.rearm_closed;
  wire wiring_open = !pins_s.select_bridged &&
                     !pins_s.rearm_closed;
  wire sync_ok  = pins_s.sync_beam;
  wire field_ok = sync_ok && pins_s.beams_clear;

  // ************************************************
  // Power-up open contact timer
  // ************************************************
  wire open_done = wiring_open &&
                   (open_cnt_q == CNT_W'(P_ALIGN_CYC - 1));
  wire sel_seen  = !wiring_open;
  wire in_pu     = state_q == ST_POWERUP;
  wire leave_pu  = in_pu && (open_done || sel_seen);

  // Count only an unbroken open span; any closure clears it and leaves power-up
  assign open_cnt_d = (in_pu && wiring_open && !open_done) ?
                      open_cnt_q + 1'b1 : '0;

  // ************************************************
  // Mode latch
  // ************************************************
  // Wiring is taken once; later changes need a power cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      align_only_q <= 1'b0;
      auto_q       <= 1'b0;
      manual_q     <= 1'b0;
    end else if (leave_pu) begin
      align_only_q <= open_done;
      auto_q       <= !open_done && sel_auto;
      manual_q     <= !open_done && sel_manual;
    end
  end

  // ************************************************
  // Operating state machine
  // ************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POWERUP: begin
        if (leave_pu) begin
          state_d = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (!align_only_q && field_ok) begin
          state_d = auto_q ? ST_RUN : ST_LOCK;
        end
      end
      ST_RUN: begin
        if (!field_ok) begin
          state_d = auto_q ? ST_TRIP : ST_LOCK;
        end
      end
      ST_TRIP: begin
        if (field_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_LOCK: begin
        if (field_ok && press_ok) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_POWERUP;
      end
    endcase
  end

  // ************************************************
  // Output and indicator decode
  // ************************************************
  // Outputs follow the next state so a trip costs no extra cycle
  assign ssw_d = (state_d == ST_RUN) ? SSW_ON : SSW_OFF;

  wire [2:0] ind_level = (pins_s.level == LVL_MAX)    ? IND_MAX :
                         (pins_s.level == LVL_MEDIUM) ? IND_MEDIUM :
                                                        IND_WEAK;
  wire [2:0] ind_qual  = !sync_ok            ? IND_NO_SYNC :
                         !pins_s.beams_clear ? IND_BLOCKED :
                                               ind_level;
  wire [2:0] ind_lock  = field_ok ? IND_LOCK_READY
                                  : IND_LOCK_OFF;
  assign ind_d = (state_q == ST_LOCK)    ? ind_lock :
                 (state_q == ST_POWERUP) ? IND_DARK :
                                           ind_qual;

  assign status_d.align_mode   = (state_q == ST_ALIGN) ||
                                 (state_q == ST_POWERUP);
  assign status_d.auto_rearm   = auto_q;
  assign status_d.manual_rearm = manual_q;
  assign status_d.rearm_lock   = state_q == ST_LOCK;
  assign status_d.sync_lost    = !sync_ok;

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q    <= ST_POWERUP;
      open_cnt_q <= '0;
      ssw_q      <= SSW_OFF;
      ind_q      <= IND_DARK;
      status_q   <= '0;
    end else begin
      state_q    <= state_d;
      open_cnt_q <= open_cnt_d;
      ssw_q      <= ssw_d;
      ind_q      <= ind_d;
      status_q   <= status_d;
    end
  end

  assign o_safety_switch_outputs = ssw_q;
  assign o_indicator             = ind_q;
  assign o_status                = status_q;

  // ************************************************
  // Assertions
  // ************************************************
  property p_off_unless_run;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q != ST_RUN) |-> (o_safety_switch_outputs == SSW_OFF);
  endproperty
  a_off_unless_run: assert property (p_off_unless_run)
    else $error("Outputs on outside normal operation");

  property p_align_entry;
    @(posedge i_clk) disable iff (!i_nrst)
    (in_pu && open_done) |=> (state_q == ST_ALIGN) && align_only_q;
  endproperty
  a_align_entry: assert property (p_align_entry)
    else $error("Open contact did not select alignment");

  property p_no_sync_ind;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_ALIGN && !sync_ok) |=> (o_indicator == IND_NO_SYNC);
  endproperty
  a_no_sync_ind: assert property (p_no_sync_ind)
    else $error("Indicator missed sync loss");

  property p_trip;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_RUN && !field_ok) |=>
      (o_safety_switch_outputs == SSW_OFF) && (state_q != ST_RUN);
  endproperty
  a_trip: assert property (p_trip)
    else $error("Interruption did not open outputs");

  property p_sync_report;
    @(posedge i_clk) disable iff (!i_nrst)
    !pins_s.sync_beam |=> o_status.sync_lost;
  endproperty
  a_sync_report: assert property (p_sync_report)
    else $error("Sync loss not reported");

  property p_auto_rearm;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_TRIP && field_ok) |=>
      (o_safety_switch_outputs == SSW_ON);
  endproperty
  a_auto_rearm: assert property (p_auto_rearm)
    else $error("Automatic rearm did not reclose");

  property p_lock_holds;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_LOCK && !(field_ok && press_ok)) |=>
      (state_q == ST_LOCK) && (o_safety_switch_outputs == SSW_OFF);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("Lock left without clear field and reset");

  property p_unlock;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_LOCK && field_ok && press_ok) |=>
      (o_safety_switch_outputs == SSW_ON);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("Valid reset did not unlock");

  property p_lock_ind;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_LOCK) |=>
      (o_indicator == ($past(field_ok) ? IND_LOCK_READY
                                        : IND_LOCK_OFF));
  endproperty
  a_lock_ind: assert property (p_lock_ind)
    else $error("Lock indicator wrong");

  property p_first_align;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_ALIGN && !align_only_q && field_ok) |=>
      (state_q == (auto_q ? ST_RUN : ST_LOCK));
  endproperty
  a_first_align: assert property (p_first_align)
    else $error("Mode not taken after alignment");

  property p_mode_decode;
    @(posedge i_clk) disable iff (!i_nrst)
    (leave_pu && !open_done && sel_auto) |=> auto_q && !manual_q;
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("Bridged wiring not decoded as automatic");

  property p_manual_decode;
    @(posedge i_clk) disable iff (!i_nrst)
    (leave_pu && !open_done && sel_manual) |=> manual_q && !auto_q;
  endproperty
  a_manual_decode: assert property (p_manual_decode)
    else $error("Closed contact not decoded as manual");

  property p_align_only_off;
    @(posedge i_clk) disable iff (!i_nrst)
    align_only_q |-> (state_q == ST_ALIGN) &&
      (o_safety_switch_outputs == SSW_OFF);
  endproperty
  a_align_only_off: assert property (p_align_only_off)
    else $error("Alignment-only unit left alignment");

  property p_on_needs_field;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_safety_switch_outputs == SSW_ON) |-> $past(field_ok);
  endproperty
  a_on_needs_field: assert property (p_on_needs_field)
    else $error("Outputs on without clear synchronised field");
endmodule

/* File: tb/lcm_partner.sv */
// Machine control and operator reset button model for the curtain bench
`timescale 1ns/1ps
module lcm_partner (
  // Clock
  input  wire logic       i_clk,
  // Safety outputs seen by the machine
  input  wire logic [1:0] i_ssw,
  // Operator button, high while pressed
  output logic            o_btn,
  // Sticky flag: the two outputs ever disagreed
  output logic            o_split
);
  // ************************************************
  // Machine side
  // ************************************************
  initial o_btn = 1'b0;
  initial o_split = 1'b0;

  // A channel mismatch would leave one contactor closed on the machine
  always @(posedge i_clk) begin
    if (i_ssw[0] !== i_ssw[1]) begin
      o_split <= 1'b1;
    end
  end

  // ************************************************
  // Operator button
  // ************************************************
  // Held for exactly n clock cycles, changed only on falling edges
  task automatic press(input int n);
    @(negedge i_clk);
    o_btn = 1'b1;
    repeat (n) @(negedge i_clk);
    o_btn = 1'b0;
  endtask
endmodule

/* File: tb/tb_lcm_top.sv */
// Self-checking bench for the light curtain mode control
`timescale 1ns/1ps
module tb_lcm_top;
  import lcm_pkg::*;

  // ************************************************
  // Shortened counts
  // ************************************************
  localparam int AL   = 20;
  localparam int HMIN = 5;
  localparam int HMAX = 12;

  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  lcm_pins_t   pins = '0;
  lcm_pins_t   pins_w;
  logic        btn;
  logic        split;
  logic [1:0]  ssw;
  logic [2:0]  ind;
  lcm_status_t stat;
  int          failures = 0;
  int          cmp_count = 0;

  always #2 i_clk = ~i_clk;

  // Button comes from the operator model, the rest from the bench
  always_comb begin
    pins_w = pins;
    pins_w.reset_btn = btn;
  end

  lcm_top #(
    .P_ALIGN_CYC(AL),
    .P_HOLD_MIN (HMIN),
    .P_HOLD_MAX (HMAX)
  ) dut (
    .i_clk                  (i_clk),
    .i_nrst                 (i_nrst),
    .i_pins                 (pins_w),
    .o_safety_switch_outputs(ssw),
    .o_indicator            (ind),
    .o_status               (stat)
  );

  lcm_partner u_part (
    .i_clk  (i_clk),
    .i_ssw  (ssw),
    .o_btn  (btn),
    .o_split(split)
  );

  // ************************************************
  // Helpers
  // ************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic report(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_ssw(input logic [1:0] exp);
    report({6'h00, ssw}, {6'h00, exp});
  endtask

  task automatic chk_ind(input logic [2:0] exp);
    report({5'h00, ind}, {5'h00, exp});
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    report({7'h00, got}, {7'h00, exp});
  endtask

  // Wiring must settle before release, it is latched at power-up
  task automatic do_reset(input logic closed, input logic bridged,
                          input logic sync, input logic clr,
                          input logic [1:0] lvl);
    @(negedge i_clk);
    i_nrst = 1'b0;
    pins.rearm_closed = closed;
    pins.select_bridged = bridged;
    pins.sync_beam = sync;
    pins.beams_clear = clr;
    pins.level = lvl;
    cyc(8);
    i_nrst = 1'b1;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************
  // Watchdog
  // ************************************************
  initial begin
    repeat (3000) @(posedge i_clk);
    failures++;
    print_verdict();
  end

  // ************************************************
  // Tests
  // ************************************************
  initial begin
    // Automatic re-arming, field blocked during alignment
    do_reset(1'b0, 1'b1, 1'b1, 1'b0, LVL_WEAK);
    cyc(1);
    chk_ssw(SSW_OFF);
    chk_ind(IND_DARK);
    chk_bit(stat.align_mode, 1'b1);
    cyc(9);
    chk_ssw(SSW_OFF);
    chk_ind(IND_BLOCKED);
    chk_bit(stat.auto_rearm, 1'b1);
    pins.beams_clear = 1'b1;
    cyc(5);
    chk_ssw(SSW_ON);
    chk_ind(IND_WEAK);
    pins.level = LVL_MEDIUM;
    cyc(5);
    chk_ind(IND_MEDIUM);
    pins.level = 2'h3;
    cyc(5);
    chk_ind(IND_WEAK);
    pins.beams_clear = 1'b0;
    cyc(5);
    chk_ssw(SSW_OFF);
    pins.beams_clear = 1'b1;
    cyc(5);
    chk_ssw(SSW_ON);
    chk_bit(stat.rearm_lock, 1'b0);
    pins.sync_beam = 1'b0;
    cyc(5);
    chk_ssw(SSW_OFF);
    chk_bit(stat.sync_lost, 1'b1);
    chk_ind(IND_NO_SYNC);
    pins.sync_beam = 1'b1;
    cyc(5);
    chk_ssw(SSW_ON);

    // Manual re-arming, starts locked after alignment
    do_reset(1'b1, 1'b0, 1'b1, 1'b1, LVL_MAX);
    cyc(10);
    chk_ssw(SSW_OFF);
    chk_bit(stat.manual_rearm, 1'b1);
    chk_bit(stat.rearm_lock, 1'b1);
    chk_ind(IND_LOCK_READY);
    u_part.press(HMIN - 1);
    cyc(10);
    chk_ssw(SSW_OFF);
    u_part.press(HMAX + 1);
    cyc(10);
    chk_ssw(SSW_OFF);
    u_part.press(HMIN);
    cyc(8);
    chk_ssw(SSW_ON);
    chk_ind(IND_MAX);
    pins.beams_clear = 1'b0;
    cyc(5);
    chk_ssw(SSW_OFF);
    chk_ind(IND_LOCK_OFF);
    u_part.press(HMIN + 2);
    cyc(8);
    chk_ssw(SSW_OFF);
    pins.beams_clear = 1'b1;
    cyc(5);
    chk_ssw(SSW_OFF);
    chk_ind(IND_LOCK_READY);
    u_part.press(HMAX);
    cyc(8);
    chk_ssw(SSW_ON);

    // Wiring open for the full span: alignment only
    do_reset(1'b0, 1'b0, 1'b1, 1'b1, LVL_MAX);
    cyc(AL + 10);
    chk_bit(stat.align_mode, 1'b1);
    chk_ssw(SSW_OFF);
    chk_ind(IND_MAX);
    pins.rearm_closed = 1'b1;
    pins.sync_beam = 1'b0;
    cyc(10);
    chk_ssw(SSW_OFF);
    chk_ind(IND_NO_SYNC);

    // Wiring open shorter than the span, then closed: manual
    do_reset(1'b0, 1'b0, 1'b1, 1'b1, LVL_MAX);
    cyc(AL - 10);
    pins.rearm_closed = 1'b1;
    cyc(10);
    chk_bit(stat.manual_rearm, 1'b1);
    chk_bit(stat.rearm_lock, 1'b1);
    chk_ssw(SSW_OFF);

    chk_bit(split, 1'b0);
    print_verdict();
  end
endmodule
